// file: rtl/bli_defines.svh
// Constants of the backlight two-wire register slave and its bus master.
`ifndef BLI_DEFINES_SVH
`define BLI_DEFINES_SVH

// ============================================================
// Addressing
`define BLI_DEV_ADDR 7'h2C
`define BLI_BYTE_BITS 4'h8
`define BLI_LAST_BIT 4'h7
`define BLI_READ_FILL 8'hFF

// ============================================================
// Register map
`define BLI_REG_BRT 8'h00
`define BLI_REG_CTRL 8'h01
`define BLI_REG_STATUS 8'h02
`define BLI_REG_DIRECT 8'h04
`define BLI_REG_LEDEN 8'h16
`define BLI_CFG_BASE 8'hA0
`define BLI_CFG_LAST 8'hAF
`define BLI_RESET_BYTE 8'h00
`define BLI_CTRL_ON_BIT 0
`define BLI_STATUS_UNDERVOLTAGE_LOCKOUT_BIT 0

// ============================================================
// Timing
`define BLI_CLK_NS 20
`define BLI_SCL_QTR_NS 2500
`define BLI_SCL_QTR_CYC ((`BLI_SCL_QTR_NS + `BLI_CLK_NS - 1) / `BLI_CLK_NS)

`endif

// file: rtl/bli_pkg.sv
// Types shared by both ends of the backlight two-wire link.
package bli_pkg;

    // ============================================================
    // Device end
    typedef enum logic [2:0] {
        DS_IDLE = 3'h0,
        DS_RX = 3'h1,
        DS_ACK = 3'h3,
        DS_TX = 3'h2,
        DS_RACK = 3'h6,
        DS_SKIP = 3'h4
    } bli_dev_state_t;

    typedef enum logic [1:0] {
        BK_ADDR = 2'h0,
        BK_PTR = 2'h1,
        BK_DATA = 2'h3
    } bli_kind_t;

    // ============================================================
    // Master end
    typedef enum logic [1:0] {
        HS_IDLE = 2'h0,
        HS_START = 2'h1,
        HS_BYTE = 2'h3,
        HS_STOP = 2'h2
    } bli_host_state_t;

endpackage : bli_pkg

// file: rtl/bli_if.sv
// Open-drain two-wire link joining the bus master and the device.
`timescale 1ns/1ps
`default_nettype none

interface bli_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // Pull-ups hold both lines high unless some party drives them.
    assign scl = host_scl_oe ? host_scl_o : 1'b1;
    assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

    modport host (output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe,
        input scl, input sda);
    modport dev (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface : bli_if

`default_nettype wire

// file: rtl/bli_sync.sv
// Two-stage synchroniser for inputs that arrive from another clock domain.
`timescale 1ns/1ps
`default_nettype none

module bli_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // ============================================================
    // Only the second stage is visible outside.
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule : bli_sync

`default_nettype wire

// file: rtl/bli_device.sv
// Device end: two-wire register slave with fault status and configuration lock.
//
// Behaviour
// - Master changes data only while clock low.
// - Data change during clock high aborts transaction.
// - Bytes are eight bits, MSB first, acknowledged.
// - Detect start and stop conditions.
// - Bus busy from start until stop.
// - Repeated start restarts address decoding.
// - Receiver pulls data low on ninth clock.
// - Master leaves last read byte unacknowledged.
// - Respond to seven-bit address 2Ch.
// - First seven bits address, eighth direction.
// - Acknowledge only own address, else passive.
// - Write: address, pointer, then data bytes.
// - Pointer increments after each written byte.
// - Read: pointer, repeated start, read address.
// - Acknowledged read byte advances pointer.
// - Reading fault status clears latched faults.
// - Undervoltage flag also clears on enable low.
// - Configuration registers locked while active.
`timescale 1ns/1ps
`default_nettype none
`include "bli_defines.svh"

module bli_device (
    input wire logic clk_link,
    input wire logic rst,
    bli_if.dev bus,
    input wire logic enable_and_io_supply_pin,
    input wire logic pwm_active,
    input wire logic [7:0] fault_evt,
    output logic [7:0] brightness,
    output logic [7:0] dev_ctrl,
    output logic [7:0] direct_ctrl,
    output logic [7:0] led_enable,
    output logic [127:0] cfg_bytes,
    output logic bus_busy,
    output logic active_mode
);
    import bli_pkg::*;

    // ============================================================
    // State
    typedef struct packed {
        bli_dev_state_t state;
        bli_kind_t kind;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic rw;
        logic mack;
        logic sda_oe;
        logic busy;
        logic scl_prev;
        logic sda_prev;
        logic [7:0] brt;
        logic [7:0] ctrl;
        logic [7:0] status;
        logic [7:0] direct;
        logic [7:0] leden;
        logic [15:0][7:0] cfg;
    } bli_dev_t;

    bli_dev_t s_reg;
    bli_dev_t s_next;

    logic [11:0] sync_q;
    logic scl_s;
    logic sda_s;
    logic en_s;
    logic pwm_s;
    logic [7:0] fault_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic locked;

    // ============================================================
    // Pin synchronisers
    // Lines and enable reset high, the fault levels low, so reset raises no false flag.
    bli_sync #(.W(12), .RST_VAL(12'hE00)) u_sync (
        .clk(clk_link),
        .rst(rst),
        .d({bus.scl, bus.sda, enable_and_io_supply_pin, pwm_active, fault_evt}),
        .q(sync_q)
    );

    assign scl_s = sync_q[11];
    assign sda_s = sync_q[10];
    assign en_s = sync_q[9];
    assign pwm_s = sync_q[8];
    // A fault level that stays asserted keeps its flag set through a read, since the set wins in the clearing cycle.
    assign fault_s = {sync_q[7:0] & {8{1'b1}}} & fault_evt_mask(sync_q[7:0]);

    assign scl_rise = scl_s & ~s_reg.scl_prev;
    assign scl_fall = ~scl_s & s_reg.scl_prev;
    assign start_det = scl_s & s_reg.scl_prev & s_reg.sda_prev & ~sda_s;
    assign stop_det = scl_s & s_reg.scl_prev & ~s_reg.sda_prev & sda_s;
    assign locked = s_reg.ctrl[`BLI_CTRL_ON_BIT] | pwm_s;

    // ============================================================
    // Register access
    function automatic logic [7:0] fault_evt_mask(input logic [7:0] f);
        fault_evt_mask = f;
    endfunction : fault_evt_mask

    function automatic logic [7:0] reg_read(input bli_dev_t st, input logic [7:0] a);
        if (a == `BLI_REG_BRT) begin
            reg_read = st.brt;
        end else if (a == `BLI_REG_CTRL) begin
            reg_read = st.ctrl;
        end else if (a == `BLI_REG_STATUS) begin
            reg_read = st.status;
        end else if (a == `BLI_REG_DIRECT) begin
            reg_read = st.direct;
        end else if (a == `BLI_REG_LEDEN) begin
            reg_read = st.leden;
        end else if (a >= `BLI_CFG_BASE && a <= `BLI_CFG_LAST) begin
            reg_read = st.cfg[a[3:0]];
        end else begin
            reg_read = `BLI_RESET_BYTE;
        end
    endfunction : reg_read

    function automatic logic is_cfg(input logic [7:0] a);
        is_cfg = (a >= `BLI_CFG_BASE) && (a <= `BLI_CFG_LAST);
    endfunction : is_cfg

    // ============================================================
    // Protocol engine
    always_comb begin
        logic [7:0] rd_clr;
        logic [7:0] tx_byte;
        logic [7:0] tx_addr;
        rd_clr = 8'h00;
        tx_addr = s_reg.ptr + 8'h01;
        tx_byte = 8'h00;
        s_next = s_reg;
        s_next.scl_prev = scl_s;
        s_next.sda_prev = sda_s;
        if (start_det) begin
            // A start inside a transaction is a repeated start; decoding begins again.
            s_next.state = DS_RX;
            s_next.kind = BK_ADDR;
            s_next.cnt = 4'h0;
            s_next.busy = 1'b1;
            s_next.sda_oe = 1'b0;
        end else if (stop_det) begin
            s_next.state = DS_IDLE;
            s_next.busy = 1'b0;
            s_next.sda_oe = 1'b0;
        end else begin
            case (s_reg.state)
                DS_RX: begin
                    if (scl_rise) begin
                        s_next.shift = {s_reg.shift[6:0], sda_s};
                        s_next.cnt = s_reg.cnt + 4'h1;
                    end else if (scl_fall && s_reg.cnt == `BLI_BYTE_BITS) begin
                        s_next.cnt = 4'h0;
                        case (s_reg.kind)
                            BK_ADDR: begin
                                if (s_reg.shift[7:1] == `BLI_DEV_ADDR) begin
                                    s_next.rw = s_reg.shift[0];
                                    s_next.sda_oe = 1'b1;
                                    s_next.state = DS_ACK;
                                end else begin
                                    s_next.state = DS_SKIP;
                                end
                            end
                            BK_PTR: begin
                                s_next.ptr = s_reg.shift;
                                s_next.sda_oe = 1'b1;
                                s_next.state = DS_ACK;
                            end
                            default: begin
                                if (s_reg.ptr == `BLI_REG_BRT) begin
                                    s_next.brt = s_reg.shift;
                                end else if (s_reg.ptr == `BLI_REG_CTRL) begin
                                    s_next.ctrl = s_reg.shift;
                                end else if (s_reg.ptr == `BLI_REG_DIRECT) begin
                                    s_next.direct = s_reg.shift;
                                end else if (s_reg.ptr == `BLI_REG_LEDEN) begin
                                    s_next.leden = s_reg.shift;
                                end else if (is_cfg(s_reg.ptr) && !locked) begin
                                    s_next.cfg[s_reg.ptr[3:0]] = s_reg.shift;
                                end
                                s_next.sda_oe = 1'b1;
                                s_next.state = DS_ACK;
                            end
                        endcase
                    end
                end
                DS_ACK: begin
                    if (scl_fall) begin
                        s_next.sda_oe = 1'b0;
                        if (s_reg.kind == BK_ADDR && s_reg.rw) begin
                            tx_byte = reg_read(s_reg, s_reg.ptr);
                            if (s_reg.ptr == `BLI_REG_STATUS) begin
                                rd_clr = 8'hFF;
                            end
                            s_next.shift = tx_byte;
                            s_next.sda_oe = ~tx_byte[7];
                            s_next.state = DS_TX;
                        end else begin
                            s_next.state = DS_RX;
                            s_next.kind = (s_reg.kind == BK_ADDR) ? BK_PTR : BK_DATA;
                            if (s_reg.kind == BK_DATA) begin
                                s_next.ptr = tx_addr;
                            end
                        end
                    end
                end
                DS_TX: begin
                    if (scl_fall) begin
                        if (s_reg.cnt == `BLI_LAST_BIT) begin
                            s_next.sda_oe = 1'b0;
                            s_next.cnt = 4'h0;
                            s_next.state = DS_RACK;
                        end else begin
                            s_next.shift = {s_reg.shift[6:0], 1'b0};
                            s_next.sda_oe = ~s_reg.shift[6];
                            s_next.cnt = s_reg.cnt + 4'h1;
                        end
                    end
                end
                DS_RACK: begin
                    if (scl_rise) begin
                        s_next.mack = ~sda_s;
                    end else if (scl_fall) begin
                        if (s_reg.mack) begin
                            tx_byte = reg_read(s_reg, tx_addr);
                            if (tx_addr == `BLI_REG_STATUS) begin
                                rd_clr = 8'hFF;
                            end
                            s_next.ptr = tx_addr;
                            s_next.shift = tx_byte;
                            s_next.sda_oe = ~tx_byte[7];
                            s_next.state = DS_TX;
                        end else begin
                            // The line is already released; wait for stop or restart.
                            s_next.state = DS_SKIP;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        if (!en_s) begin
            rd_clr[`BLI_STATUS_UNDERVOLTAGE_LOCKOUT_BIT] = 1'b1;
        end
        // A fault arriving in the clearing cycle is kept: the set wins.
        s_next.status = (s_reg.status & ~rd_clr) | fault_s;
    end

    always_ff @(posedge clk_link) begin
        if (rst) begin
            s_reg <= '{state: DS_IDLE, kind: BK_ADDR, cnt: 4'h0, shift: 8'h00, ptr: 8'h00,
                rw: 1'b0, mack: 1'b0, sda_oe: 1'b0, busy: 1'b0, scl_prev: 1'b1, sda_prev: 1'b1,
                brt: 8'h00, ctrl: 8'h00, status: 8'h00, direct: 8'h00, leden: 8'h00,
                cfg: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // ============================================================
    // Outputs
    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe = s_reg.sda_oe;
    assign brightness = s_reg.brt;
    assign dev_ctrl = s_reg.ctrl;
    assign direct_ctrl = s_reg.direct;
    assign led_enable = s_reg.leden;
    assign cfg_bytes = s_reg.cfg;
    assign bus_busy = s_reg.busy;
    assign active_mode = locked;
endmodule : bli_device

`default_nettype wire

// file: rtl/bli_host.sv
// Master end: issues single-byte register writes and reads on the two-wire link.
`timescale 1ns/1ps
`default_nettype none
`include "bli_defines.svh"

module bli_host #(
    parameter int QTR = `BLI_SCL_QTR_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    bli_if.host bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic [7:0] cmd_ptr,
    input wire logic [7:0] cmd_wdata,
    output logic done,
    output logic err,
    output logic [7:0] rd_data
);
    import bli_pkg::*;

    // ============================================================
    // State
    typedef struct packed {
        bli_host_state_t st;
        logic [1:0] ph;
        logic [15:0] tcnt;
        logic [1:0] step;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic ack_ok;
        logic rd;
        logic [7:0] ptr;
        logic [7:0] wdata;
        logic scl_oe;
        logic sda_oe;
        logic done;
        logic err;
        logic [7:0] rd_data;
    } bli_host_t;

    bli_host_t s_reg;
    bli_host_t s_next;
    logic sda_s;
    logic tick;

    bli_sync #(.W(1), .RST_VAL(1'b1)) u_sync (
        .clk(clk_sys),
        .rst(rst),
        .d(bus.sda),
        .q(sda_s)
    );

    assign tick = (s_reg.tcnt == 16'(QTR - 1));

    function automatic logic [7:0] byte_for(input bli_host_t st, input logic [1:0] step);
        case (step)
            2'h0: byte_for = {`BLI_DEV_ADDR, 1'b0};
            2'h1: byte_for = st.ptr;
            2'h2: byte_for = st.rd ? {`BLI_DEV_ADDR, 1'b1} : st.wdata;
            default: byte_for = `BLI_READ_FILL;
        endcase
    endfunction : byte_for

    // ============================================================
    // Bit sequencer; the clock is divided down from clk_sys in quarter periods.
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.tcnt = tick ? 16'h0000 : s_reg.tcnt + 16'h0001;
        case (s_reg.st)
            HS_IDLE: begin
                s_next.tcnt = 16'h0000;
                if (cmd_valid) begin
                    s_next.rd = cmd_read;
                    s_next.ptr = cmd_ptr;
                    s_next.wdata = cmd_wdata;
                    s_next.step = 2'h0;
                    s_next.ph = 2'h0;
                    s_next.err = 1'b0;
                    s_next.st = HS_START;
                end
            end
            HS_START: begin
                if (tick) begin
                    s_next.ph = s_reg.ph + 2'h1;
                    case (s_reg.ph)
                        2'h0: s_next.sda_oe = 1'b0;
                        2'h1: s_next.scl_oe = 1'b0;
                        2'h2: s_next.sda_oe = 1'b1;
                        default: begin
                            s_next.scl_oe = 1'b1;
                            s_next.bitn = 4'h0;
                            s_next.sh = byte_for(s_reg, s_reg.step);
                            s_next.st = HS_BYTE;
                        end
                    endcase
                end
            end
            HS_BYTE: begin
                if (tick) begin
                    s_next.ph = s_reg.ph + 2'h1;
                    case (s_reg.ph)
                        2'h0: s_next.sda_oe = (s_reg.bitn != `BLI_BYTE_BITS) && (s_reg.step != 2'h3)
                            && !s_reg.sh[7];
                        2'h1: s_next.scl_oe = 1'b0;
                        2'h2: begin
                            if (s_reg.bitn != `BLI_BYTE_BITS) begin
                                s_next.sh = {s_reg.sh[6:0], sda_s};
                            end else begin
                                s_next.ack_ok = ~sda_s;
                            end
                        end
                        default: begin
                            s_next.scl_oe = 1'b1;
                            s_next.bitn = s_reg.bitn + 4'h1;
                            if (s_reg.bitn == `BLI_BYTE_BITS) begin
                                s_next.bitn = 4'h0;
                                s_next.step = s_reg.step + 2'h1;
                                s_next.sh = byte_for(s_reg, s_reg.step + 2'h1);
                                if (s_reg.step == 2'h3) begin
                                    s_next.rd_data = s_reg.sh;
                                    s_next.st = HS_STOP;
                                end else if (!s_reg.ack_ok) begin
                                    s_next.err = 1'b1;
                                    s_next.st = HS_STOP;
                                end else if (s_reg.step == 2'h2 && !s_reg.rd) begin
                                    s_next.st = HS_STOP;
                                end else if (s_reg.step == 2'h1 && s_reg.rd) begin
                                    s_next.st = HS_START;
                                end
                            end
                        end
                    endcase
                end
            end
            default: begin
                if (tick) begin
                    s_next.ph = s_reg.ph + 2'h1;
                    case (s_reg.ph)
                        2'h0: s_next.sda_oe = 1'b1;
                        2'h1: s_next.scl_oe = 1'b0;
                        2'h2: s_next.sda_oe = 1'b0;
                        default: begin
                            s_next.done = 1'b1;
                            s_next.st = HS_IDLE;
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ============================================================
    // Outputs
    assign cmd_ready = (s_reg.st == HS_IDLE);
    assign bus.host_scl_o = 1'b0;
    assign bus.host_scl_oe = s_reg.scl_oe;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_sda_oe = s_reg.sda_oe;
    assign done = s_reg.done;
    assign err = s_reg.err;
    assign rd_data = s_reg.rd_data;
endmodule : bli_host

`default_nettype wire

// file: verif/bli_link_assertions.sv
// Assertions on the two-wire link between the bus master and the device.
`timescale 1ns/1ps
`default_nettype none
`include "bli_defines.svh"

// ============================================================
// Link checker
module bli_link_assertions #(
    parameter int QTR = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    localparam int LMIN = QTR;
    localparam int LMAX = 2 * QTR;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic first;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Bit counter restarts on every start, so a repeated start re-arms the address match.
    always_ff @(posedge clk_sys) begin
        if (rst || (scl && $fell(sda))) begin
            cnt <= 4'h0;
            first <= 1'b1;
        end else if ($rose(scl) && cnt == 4'h8) begin
            cnt <= 4'h0;
            first <= 1'b0;
        end else if ($rose(scl)) begin
            cnt <= cnt + 4'h1;
            sh <= {sh[6:0], sda};
        end
    end

    property p_ack_rise; $rose(dev_sda_oe) |-> !scl; endproperty
    a_ack_rise: assert property (p_ack_rise) else $error("device drove data while clock high");
    property p_release; $fell(dev_sda_oe) |-> !scl; endproperty
    a_release: assert property (p_release) else $error("device released data while clock high");
    // Both ends may pull low together at the ack handover; a clock-high overlap is the conflict.
    property p_one_driver; scl && dev_sda_oe |-> !host_sda_oe; endproperty
    a_one_driver: assert property (p_one_driver) else $error("both ends drive data");
    property p_dev_stable; scl && $past(scl) |-> $stable(dev_sda_oe); endproperty
    a_dev_stable: assert property (p_dev_stable) else $error("device data moved in clock high");
    property p_start; scl && $fell(sda) |-> scl [*4] ##[1:LMAX] !scl; endproperty
    a_start: assert property (p_start) else $error("start not followed by clock low");
    property p_stop; scl && $rose(sda) |-> scl [*8]; endproperty
    a_stop: assert property (p_stop) else $error("clock not idle after stop");
    property p_low_time; $fell(scl) |-> (!scl) [*8] ##[LMIN:LMAX] scl; endproperty
    a_low_time: assert property (p_low_time) else $error("clock low time wrong");
    property p_addr_ack; $rose(scl) && cnt == 4'h8 && first && sh[7:1] == `BLI_DEV_ADDR |-> !sda; endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");
endmodule : bli_link_assertions

`default_nettype wire

// file: verif/backlight_i2c_register_slave_bench.sv
// Self-checking bench: master and device joined over the two-wire link.
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Bench top
module backlight_i2c_register_slave_bench;
    localparam int QTR = 16;
    logic clk_sys, clk_link, rst, rst_link, cmd_valid, cmd_ready, cmd_read, done, err;
    logic en_pin, pwm_act, bus_busy, active_mode;
    logic [7:0] cmd_ptr, cmd_wdata, rd_data, fault_evt, brightness;
    logic [127:0] cfg_bytes;
    logic [2:0] rsh;
    logic [7:0] regs [4] = '{8'h00, 8'h04, 8'h16, 8'hAF};
    int err_total, n_tests;

    bli_if bus_if ();
    bli_host #(.QTR(QTR)) i_bli_host (.clk_sys(clk_sys), .rst(rst), .bus(bus_if.host), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_ptr(cmd_ptr), .cmd_wdata(cmd_wdata), .done(done),
        .err(err), .rd_data(rd_data));
    bli_device i_bli_device (.clk_link(clk_link), .rst(rst_link), .bus(bus_if.dev), .enable_and_io_supply_pin(en_pin),
        .pwm_active(pwm_act), .fault_evt(fault_evt), .brightness(brightness), .dev_ctrl(), .direct_ctrl(),
        .led_enable(), .cfg_bytes(cfg_bytes), .bus_busy(bus_busy), .active_mode(active_mode));
    bli_link_assertions #(.QTR(QTR)) u_chk (.clk_sys(clk_sys), .rst(rst), .host_sda_oe(bus_if.host_sda_oe),
        .dev_sda_oe(bus_if.dev_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        clk_link = 1'b0;
        #7;
        forever #24 clk_link = ~clk_link;
    end
    // Six system cycles are under three link edges, so the link reset is stretched.
    always @(posedge clk_link) rsh <= {rsh[1:0], rst};
    assign rst_link = rst | (|rsh);

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic xfer(input logic rd, input logic [7:0] ptr, input logic [7:0] wd);
        cmd_valid <= 1'b1;
        cmd_read <= rd;
        cmd_ptr <= ptr;
        cmd_wdata <= wd;
        do @(negedge clk_sys); while (cmd_ready !== 1'b1);
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        do @(negedge clk_sys); while (done !== 1'b1);
        @(posedge clk_sys);
    endtask : xfer

    task automatic rdchk(input logic [7:0] ptr, input logic [7:0] exp);
        xfer(1'b1, ptr, 8'h00);
        chk(rd_data, exp);
        chk({7'h00, err}, 8'h00);
    endtask : rdchk

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    initial begin
        #1600000;
        err_total++;
        summarize();
    end

    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_read = 1'b0;
        cmd_ptr = 8'h00;
        cmd_wdata = 8'h00;
        en_pin = 1'b1;
        pwm_act = 1'b0;
        fault_evt = 8'h00;
        err_total = 0;
        n_tests = 0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        xfer(1'b0, 8'h00, 8'h81);
        chk(brightness, 8'h81);
        chk({7'h00, bus_busy}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, regs[i], 8'h3C ^ regs[i]);
            rdchk(regs[i], 8'h3C ^ regs[i]);
        end
        rdchk(8'h10, 8'h00);
        $display("test 1 done");
        xfer(1'b0, 8'hA3, 8'h5A);
        xfer(1'b0, 8'h01, 8'h01);
        chk({7'h00, active_mode}, 8'h01);
        xfer(1'b0, 8'hA3, 8'hC3);
        rdchk(8'hA3, 8'h5A);
        chk(cfg_bytes[31:24], 8'h5A);
        xfer(1'b0, 8'h01, 8'h00);
        pwm_act <= 1'b1;
        xfer(1'b0, 8'hA3, 8'h11);
        pwm_act <= 1'b0;
        rdchk(8'hA3, 8'h5A);
        xfer(1'b0, 8'hA3, 8'h66);
        rdchk(8'hA3, 8'h66);
        $display("test 2 done");
        fault_evt <= 8'h81;
        repeat (20) @(posedge clk_sys);
        fault_evt <= 8'h00;
        xfer(1'b0, 8'h02, 8'hFF);
        rdchk(8'h02, 8'h81);
        rdchk(8'h02, 8'h00);
        fault_evt <= 8'h41;
        repeat (20) @(posedge clk_sys);
        fault_evt <= 8'h00;
        en_pin <= 1'b0;
        repeat (20) @(posedge clk_sys);
        en_pin <= 1'b1;
        rdchk(8'h02, 8'h40);
        $display("test 3 done");
        summarize();
    end
endmodule : backlight_i2c_register_slave_bench

`default_nettype wire
